/* File: bench/utt_core_model.sv */
// Model of the fetch and execute units that issue lookups to the buffer
module utt_core_model (
  // Clock
  input  wire logic                       pclk,
  // Lookup request
  output logic                            req_valid,
  output logic                            req_instr,
  output logic                            req_store,
  output logic [utt_pkg::EA_W-1:0]        req_ea,
  // Lookup response
  input  wire logic                       rsp_valid,
  input  wire logic [utt_pkg::EA_W-1:0]   rsp_real_addr,
  input  wire logic                       rsp_miss,
  input  wire logic                       rsp_prot_fault,
  input  wire logic [utt_pkg::ATTR_W-1:0] rsp_attr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_instr = 1'b0;
    req_store = 1'b0;
    req_ea    = 32'h00000000;
  end

  // One-cycle request, answer taken one edge later
  task automatic lookup(input logic instr, input logic store, input logic [31:0] ea,
                        output logic ok, output logic [31:0] ra, output logic miss,
                        output logic prot, output logic [5:0] attr);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_instr <= instr;
    req_store <= store;
    req_ea    <= ea;
    @(posedge pclk);
    req_valid <= 1'b0;
    // Released lines show the inverse so a stale address is never trusted
    req_ea    <= ~ea;
    req_instr <= ~instr;
    req_store <= ~store;
    #1;
    ok   = rsp_valid;
    ra   = rsp_real_addr;
    miss = rsp_miss;
    prot = rsp_prot_fault;
    attr = rsp_attr;
  endtask : lookup
endmodule : utt_core_model

/* File: bench/utt_unified_tlb_tb_top.sv */
// Self-checking testbench for the unified translation buffer
module utt_unified_tlb_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] EA0 = 32'h10A5C3F1;
  localparam logic [31:0] RA0 = 32'hC096B7F1;
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h00000000;
  logic        irq_entry = 1'b0;
  logic        ce        = 1'b1;
  logic [31:0] prdata, req_ea, rsp_real_addr;
  logic        pready, pslverr, req_valid, req_instr, req_store;
  logic        rsp_valid, rsp_miss, rsp_prot_fault;
  logic [5:0]  rsp_attr;
  int          errors      = 0;
  int          comparisons = 0;

  // Clock at 40 MHz
  always #12.5 pclk = ~pclk;

  utt_unified_tlb u_utt_unified_tlb (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_entry(irq_entry), .req_valid(req_valid),
    .req_instr(req_instr), .req_store(req_store), .req_ea(req_ea), .rsp_valid(rsp_valid),
    .rsp_real_addr(rsp_real_addr), .rsp_miss(rsp_miss), .rsp_prot_fault(rsp_prot_fault),
    .rsp_attr(rsp_attr)
  );

  utt_core_model u_utt_core_model (
    .pclk(pclk), .req_valid(req_valid), .req_instr(req_instr), .req_store(req_store),
    .req_ea(req_ea), .rsp_valid(rsp_valid), .rsp_real_addr(rsp_real_addr),
    .rsp_miss(rsp_miss), .rsp_prot_fault(rsp_prot_fault), .rsp_attr(rsp_attr)
  );

  // Verdict and end of run
  task automatic end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Word compare; flags are zero-extended so an unknown still mismatches
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      errors++;
      end_of_test();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk32(r, exp);
  endtask : rdc

  // Write tag and data of one entry with the current process id
  task automatic put(input logic [5:0] idx, input logic [31:0] tag, input logic [31:0] dat);
    wr(utt_pkg::OFF_INDEX, {26'h0, idx});
    wr(utt_pkg::OFF_TAG, tag);
    wr(utt_pkg::OFF_DATA, dat);
    wr(utt_pkg::OFF_CMD, 32'h00000003);
  endtask : put

  // One lookup and its full judgement; attributes checked unless a protection fault is expected
  task automatic look(input logic i, input logic s, input logic [31:0] ea,
                      input logic [31:0] ra, input logic m, input logic p, input logic [5:0] at);
    logic [31:0] gra;
    logic [5:0]  gat;
    logic        v, gm, gp;
    u_utt_core_model.lookup(i, s, ea, v, gra, gm, gp, gat);
    chk32({31'h0, v}, 32'h00000001);
    chk32(gra, ra);
    chk32({30'h0, gm, gp}, {30'h0, m, p});
    if (!p) begin
      chk32({26'h0, gat}, {26'h0, at});
    end
  endtask : look

  // Reset values, refused addresses, pass-through with translation off
  task automatic t_reset;
    logic [31:0] r;
    logic        e;
    rdc(utt_pkg::OFF_CTRL, 32'h00000000);
    rdc(utt_pkg::OFF_PID, 32'h00000000);
    apb(1'b0, 8'h40, 32'h00000000, r, e);
    chk32({31'h0, e}, 32'h00000001);
    chk32(r, 32'h00000000);
    apb(1'b1, 8'h06, 32'hFFFFFFFF, r, e);
    chk32({31'h0, e}, 32'h00000001);
    look(1'b0, 1'b0, 32'h12345678, 32'h12345678, 1'b0, 1'b0, 6'h00);
  endtask : t_reset

  // Every page size: hit, top offset bit passes, lowest compared bit misses
  task automatic t_sizes;
    logic [31:0] hm, ea, e1, e2, real_page_number;
    wr(utt_pkg::OFF_ZONE, 32'hFFFFFFFF);
    wr(utt_pkg::OFF_CTRL, 32'h00000002);
    for (int s = 0; s < 8; s++) begin
      hm  = 32'hFFFFFFFF << (10 + 2 * s);
      ea  = {8'h10 + 8'(2 * s), 24'hA5C3F1};
      e1  = ea ^ (32'h1 << (9 + 2 * s));
      e2  = ea ^ (32'h1 << (10 + 2 * s));
      real_page_number = {8'hC0 + 8'(s), 24'h96B74C} & hm;
      put(6'(9 * s), {4'h0, ea[31:10], 3'(s), 1'b1, 2'(s)}, real_page_number | 32'h300 | 32'(s));
      look(1'b0, 1'b0, ea, real_page_number | (ea & ~hm), 1'b0, 1'b0, {4'(s), 2'(s)});
      look(1'b0, 1'b0, e1, real_page_number | (e1 & ~hm), 1'b0, 1'b0, {4'(s), 2'(s)});
      look(1'b0, 1'b0, e2, e2, 1'b1, 1'b0, 6'h00);
    end
  endtask : t_sizes

  // Process id match, global entry, search and read-back
  task automatic t_tid;
    wr(utt_pkg::OFF_PID, 32'h0000005A);
    put(6'h28, 32'h07700004, 32'h0ABCD700);
    look(1'b0, 1'b0, 32'h77000123, 32'h0ABCD523, 1'b0, 1'b0, 6'h00);
    wr(utt_pkg::OFF_PID, 32'h00000033);
    look(1'b0, 1'b0, 32'h77000123, 32'h77000123, 1'b1, 1'b0, 6'h00);
    look(1'b0, 1'b0, EA0, RA0, 1'b0, 1'b0, 6'h00);
    wr(utt_pkg::OFF_SEARCH, 32'h77000123);
    wr(utt_pkg::OFF_CMD, 32'h00000010);
    rdc(utt_pkg::OFF_STATUS, 32'h00000000);
    wr(utt_pkg::OFF_PID, 32'h0000005A);
    wr(utt_pkg::OFF_CMD, 32'h00000010);
    rdc(utt_pkg::OFF_STATUS, 32'h80000028);
    wr(utt_pkg::OFF_PID, 32'h00000000);
    wr(utt_pkg::OFF_INDEX, 32'h00000028);
    wr(utt_pkg::OFF_TAG, 32'h00000000);
    wr(utt_pkg::OFF_DATA, 32'h00000000);
    wr(utt_pkg::OFF_CMD, 32'h0000000C);
    rdc(utt_pkg::OFF_PID, 32'h0000005A);
    rdc(utt_pkg::OFF_TAG, 32'h07700004);
    rdc(utt_pkg::OFF_DATA, 32'h0ABCD700);
  endtask : t_tid

  // Relocate bits act apart; an interrupt clears both
  task automatic t_irq;
    wr(utt_pkg::OFF_CTRL, 32'h00000002);
    look(1'b1, 1'b0, EA0, EA0, 1'b0, 1'b0, 6'h00);
    look(1'b0, 1'b0, EA0, RA0, 1'b0, 1'b0, 6'h00);
    wr(utt_pkg::OFF_CTRL, 32'h00000001);
    look(1'b0, 1'b0, EA0, EA0, 1'b0, 1'b0, 6'h00);
    look(1'b1, 1'b0, EA0, RA0, 1'b0, 1'b0, 6'h00);
    look(1'b1, 1'b0, 32'h12A5C3F1, 32'h12A5C3F1, 1'b0, 1'b1, 6'h00);
    wr(utt_pkg::OFF_CTRL, 32'h00000003);
    @(posedge pclk);
    irq_entry <= 1'b1;
    @(posedge pclk);
    irq_entry <= 1'b0;
    rdc(utt_pkg::OFF_CTRL, 32'h00000000);
    look(1'b0, 1'b0, EA0, EA0, 1'b0, 1'b0, 6'h00);
  endtask : t_irq

  // Zone codes against fetch, load and store; coherent bit has no effect
  task automatic t_perm;
    logic [1:0] zc [3];
    logic       f;
    zc = '{2'b01, 2'b11, 2'b00};
    put(6'h29, 32'h03300004, 32'h44000052);
    wr(utt_pkg::OFF_CTRL, 32'h00000003);
    for (int z = 0; z < 3; z++) begin
      wr(utt_pkg::OFF_ZONE, ~(32'h3 << 10) | (32'(zc[z]) << 10));
      for (int k = 0; k < 3; k++) begin
        f = (zc[z] == utt_pkg::ZONE_NONE) || (zc[z] != utt_pkg::ZONE_ALL && k != 1);
        look(k == 0, k == 2, 32'h330000A4, f ? 32'h330000A4 : 32'h440000A4,
             1'b0, f, 6'h08);
      end
    end
  endtask : t_perm

  // Enable low freezes state, so an interrupt then is not taken
  task automatic t_freeze;
    @(posedge pclk);
    ce        <= 1'b0;
    irq_entry <= 1'b1;
    repeat (3) @(posedge pclk);
    irq_entry <= 1'b0;
    ce        <= 1'b1;
    rdc(utt_pkg::OFF_CTRL, 32'h00000003);
  endtask : t_freeze

  // Invalidate all turns former hits into misses
  task automatic t_inval;
    wr(utt_pkg::OFF_CMD, 32'h00000020);
    look(1'b0, 1'b0, EA0, EA0, 1'b1, 1'b0, 6'h00);
    look(1'b0, 1'b0, 32'h330000A4, 32'h330000A4, 1'b1, 1'b0, 6'h00);
  endtask : t_inval

  // Main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_sizes();
    t_tid();
    t_irq();
    t_perm();
    t_freeze();
    t_inval();
    end_of_test();
  end
endmodule : utt_unified_tlb_tb_top

/* File: design/utt_pkg.sv */
// Shared constants for the unified translation buffer
package utt_pkg;
  // Geometry
  localparam int NUM_ENTRIES  = 64;
  localparam int EA_W         = 32;
  localparam int EPN_W        = 22;
  localparam int OFS_W        = EA_W - EPN_W;
  localparam int PID_W        = 8;
  localparam int SIZE_W       = 3;
  localparam int ZONE_SELECT_W       = 4;
  localparam int TAG_W        = 28;
  localparam int APB_AW       = 8;
  localparam int ATTR_W       = 6;
  localparam logic [EPN_W-1:0] EPN_MASK_ALL = 22'h3FFFFF;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] OFF_PID    = 8'h04;
  localparam logic [APB_AW-1:0] OFF_ZONE   = 8'h08;
  localparam logic [APB_AW-1:0] OFF_INDEX  = 8'h0C;
  localparam logic [APB_AW-1:0] OFF_TAG    = 8'h10;
  localparam logic [APB_AW-1:0] OFF_DATA   = 8'h14;
  localparam logic [APB_AW-1:0] OFF_CMD    = 8'h18;
  localparam logic [APB_AW-1:0] OFF_SEARCH = 8'h1C;
  localparam logic [APB_AW-1:0] OFF_STATUS = 8'h20;

  // Tag word fields: epn, size, valid, endian, user
  localparam int TAG_EPN_LSB  = 6;
  localparam int TAG_SIZE_LSB = 3;
  localparam int TAG_V_BIT    = 2;
  localparam int TAG_E_BIT    = 1;
  localparam int TAG_U_BIT    = 0;

  // Data word fields: rpn, execute, write, zone, W I M G
  localparam int DAT_RPN_LSB  = 10;
  localparam int DAT_EX_BIT   = 9;
  localparam int DAT_WR_BIT   = 8;
  localparam int DAT_ZONE_SELECT_LSB = 4;
  localparam int DAT_W_BIT    = 3;
  localparam int DAT_I_BIT    = 2;
  localparam int DAT_M_BIT    = 1;
  localparam int DAT_G_BIT    = 0;

  // Control, command and status bits
  localparam int CTRL_IR_BIT  = 0;
  localparam int CTRL_DR_BIT  = 1;
  localparam int CMD_WR_TAG   = 0;
  localparam int CMD_WR_DAT   = 1;
  localparam int CMD_RD_TAG   = 2;
  localparam int CMD_RD_DAT   = 3;
  localparam int CMD_SEARCH   = 4;
  localparam int CMD_INVAL    = 5;
  localparam int STAT_HIT_BIT = 31;

  // Zone codes and special values
  localparam logic [1:0]       ZONE_NONE  = 2'h0;
  localparam logic [1:0]       ZONE_ALL   = 2'h3;
  localparam logic [PID_W-1:0] TID_GLOBAL = 8'h00;

  // Reset values
  localparam logic             RST_RELOC = 1'h0;
  localparam logic [PID_W-1:0] RST_PID   = 8'h00;
  localparam logic [31:0]      RST_WORD  = 32'h00000000;
  localparam logic [TAG_W-1:0] RST_TAG   = 28'h0000000;
endpackage : utt_pkg

/* File: design/utt_unified_tlb.sv */
// Unified 64-entry translation buffer with APB maintenance registers
// Behaviour
// - Translate 32-bit fetch and data addresses
// - Separate instruction and data relocate bits
// - Translation off passes address unchanged
// - Interrupt clears both relocate bits
// - Process id extends address to 40 bits
// - 64 shared entries compared in parallel
// - Entry has 36-bit tag, 32-bit data
// - Size code picks 1KB to 16MB
// - Compare 22 down to 8 bits
// - Real page replaces compared bits only
// - Only valid entries match; miss faults
// - Identifier zero matches every process
// - Entry write takes identifier from pid
// - Entry read returns identifier to pid
// - Search finds entry matching an address
// - Invalidate all clears every valid bit, except an entry tag-written by the same command
// - Valid match grants read unless zoned
// - Zone select picks one of sixteen
// - Execute and write enables, zone override
// - Faults are precise and restartable
// - Data part yields page, controls, attributes
// - Coherent bit stored but has no effect
module utt_unified_tlb #(
  parameter int NUM_ENTRIES = utt_pkg::NUM_ENTRIES
) (
  // Clock, reset, enable
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        ce,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [utt_pkg::APB_AW-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Core events
  input  wire logic                        irq_entry,
  // Lookup request
  input  wire logic                        req_valid,
  input  wire logic                        req_instr,
  input  wire logic                        req_store,
  input  wire logic [utt_pkg::EA_W-1:0]    req_ea,
  // Lookup response
  output logic                             rsp_valid,
  output logic      [utt_pkg::EA_W-1:0]    rsp_real_addr,
  output logic                             rsp_miss,
  output logic                             rsp_prot_fault,
  output logic      [utt_pkg::ATTR_W-1:0]  rsp_attr
);
  localparam int IW = $clog2(NUM_ENTRIES);
  localparam int EW = utt_pkg::EPN_W;
  localparam int TW = utt_pkg::TAG_W;
  localparam int PW = utt_pkg::PID_W;

  // Software visible state
  logic          ir_reg;
  logic          dr_reg;
  logic [PW-1:0] pid_reg;
  logic [31:0]   zone_protection_reg;
  logic [IW-1:0] idx_reg;
  logic [TW-1:0] tag_stage_reg;
  logic [31:0]   dat_stage_reg;
  logic [31:0]   search_ea_reg;
  logic          srch_hit_reg;
  logic [IW-1:0] srch_idx_reg;
  logic          pready_reg;
  logic          pslverr_reg;
  logic [31:0]   prdata_reg;
  logic          rsp_valid_reg;
  logic [31:0]   rsp_addr_reg;
  logic          rsp_miss_reg;
  logic          rsp_prot_reg;
  logic [5:0]    rsp_attr_reg;

  // Entry storage, tag and identifier form the 36-bit tag part
  logic [TW-1:0] tag_mem [NUM_ENTRIES];
  logic [PW-1:0] tid_mem [NUM_ENTRIES];
  logic [31:0]   dat_mem [NUM_ENTRIES];

  // APB decode
  wire apb_acc   = psel & penable;
  wire xfer_done = apb_acc & pready_reg;
  wire wr_fire   = xfer_done & pwrite;
  wire addr_ok   = (paddr[1:0] == 2'h0) && (paddr <= utt_pkg::OFF_STATUS);
  wire wr_ctrl   = wr_fire && (paddr == utt_pkg::OFF_CTRL);
  wire wr_pid    = wr_fire && (paddr == utt_pkg::OFF_PID);
  wire wr_zone   = wr_fire && (paddr == utt_pkg::OFF_ZONE);
  wire wr_index  = wr_fire && (paddr == utt_pkg::OFF_INDEX);
  wire wr_tag    = wr_fire && (paddr == utt_pkg::OFF_TAG);
  wire wr_data   = wr_fire && (paddr == utt_pkg::OFF_DATA);
  wire wr_cmd    = wr_fire && (paddr == utt_pkg::OFF_CMD);
  wire wr_search = wr_fire && (paddr == utt_pkg::OFF_SEARCH);

  // Maintenance commands fire on the write edge of the command word
  wire cmd_wr_tag = wr_cmd & pwdata[utt_pkg::CMD_WR_TAG];
  wire cmd_wr_dat = wr_cmd & pwdata[utt_pkg::CMD_WR_DAT];
  wire cmd_rd_tag = wr_cmd & pwdata[utt_pkg::CMD_RD_TAG];
  wire cmd_rd_dat = wr_cmd & pwdata[utt_pkg::CMD_RD_DAT];
  wire cmd_search = wr_cmd & pwdata[utt_pkg::CMD_SEARCH];
  wire cmd_inval  = wr_cmd & pwdata[utt_pkg::CMD_INVAL];

  // Per-entry match vectors
  logic [NUM_ENTRIES-1:0] lk_hit;
  logic [NUM_ENTRIES-1:0] sr_hit;
  logic [NUM_ENTRIES-1:0] vld_vec;

  // Virtual address: process id joined to the effective address
  wire [PW+31:0] lk_va = {pid_reg, req_ea};
  wire [PW+31:0] sr_va = {pid_reg, search_ea_reg};

  // One compare and one store per entry, all checked together
  for (genvar g = 0; g < NUM_ENTRIES; g++) begin : g_ent
    wire [EW-1:0] effective_page_number  = tag_mem[g][utt_pkg::TAG_EPN_LSB +: EW];
    wire [2:0]    size = tag_mem[g][utt_pkg::TAG_SIZE_LSB +: 3];
    // Each size step drops two more low bits from the compare mask
    wire [EW-1:0] cmp  = utt_pkg::EPN_MASK_ALL << {size, 1'b0};
    wire          vld  = tag_mem[g][utt_pkg::TAG_V_BIT];
    wire          tidm = (tid_mem[g] == utt_pkg::TID_GLOBAL) ||
                         (tid_mem[g] == pid_reg);
    assign vld_vec[g] = vld;
    assign lk_hit[g]  = vld & tidm &
                        (((effective_page_number ^ lk_va[31:10]) & cmp) == '0);
    assign sr_hit[g]  = vld & tidm &
                        (((effective_page_number ^ sr_va[31:10]) & cmp) == '0);

    // Entry write, or valid bit cleared by invalidate all
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tag_mem[g] <= utt_pkg::RST_TAG;
        tid_mem[g] <= utt_pkg::RST_PID;
        dat_mem[g] <= utt_pkg::RST_WORD;
      end else if (ce) begin
        if (cmd_wr_tag && (idx_reg == IW'(g))) begin
          tag_mem[g] <= tag_stage_reg;
          tid_mem[g] <= pid_reg;
        end else if (cmd_inval) begin
          tag_mem[g][utt_pkg::TAG_V_BIT] <= 1'b0;
        end
        if (cmd_wr_dat && (idx_reg == IW'(g))) begin
          dat_mem[g] <= dat_stage_reg;
        end
      end
    end
  end

  // Index encoders; duplicate matches merge, which is left undefined
  logic [IW-1:0] lk_idx;
  logic [IW-1:0] sr_idx;
  always_comb begin
    lk_idx = '0;
    sr_idx = '0;
    // No priority among hits; a clean table has at most one
    for (int i = 0; i < NUM_ENTRIES; i++) begin
      if (lk_hit[i]) lk_idx = lk_idx | IW'(i);
      if (sr_hit[i]) sr_idx = sr_idx | IW'(i);
    end
  end

  // Selected entry fields
  wire          lk_any  = |lk_hit;
  wire [TW-1:0] lk_tag  = tag_mem[lk_idx];
  wire [31:0]   lk_dat  = dat_mem[lk_idx];
  wire [2:0]    lk_size = lk_tag[utt_pkg::TAG_SIZE_LSB +: 3];
  wire [EW-1:0] lk_mask = utt_pkg::EPN_MASK_ALL << {lk_size, 1'b0};
  wire [EW-1:0] lk_rpn  = lk_dat[utt_pkg::DAT_RPN_LSB +: EW];
  wire [EW-1:0] ra_hi   = (lk_rpn & lk_mask) | (req_ea[31:10] & ~lk_mask);
  wire [31:0]   ra_xl   = {ra_hi, req_ea[utt_pkg::OFS_W-1:0]};

  // Zone override: none denies all, all grants all except fetch from a guarded page, else entry bits
  wire [3:0] zone_select    = lk_dat[utt_pkg::DAT_ZONE_SELECT_LSB +: utt_pkg::ZONE_SELECT_W];
  wire [1:0] zone    = zone_protection_reg[{zone_select, 1'b0} +: 2];
  wire       zone_all = (zone == utt_pkg::ZONE_ALL);
  wire       rd_ok   = (zone != utt_pkg::ZONE_NONE);
  wire       guarded = lk_dat[utt_pkg::DAT_G_BIT];
  wire       ex_ok   = (zone_all | (rd_ok & lk_dat[utt_pkg::DAT_EX_BIT])) &
                       ~guarded;
  wire       wr_ok   = zone_all | (rd_ok & lk_dat[utt_pkg::DAT_WR_BIT]);
  wire       perm_ok = req_instr ? ex_ok : (req_store ? wr_ok : rd_ok);

  // Attributes W I M G E U; M is carried but steers nothing
  wire [5:0] lk_attr = {lk_dat[utt_pkg::DAT_W_BIT], lk_dat[utt_pkg::DAT_I_BIT],
                        lk_dat[utt_pkg::DAT_M_BIT], lk_dat[utt_pkg::DAT_G_BIT],
                        lk_tag[utt_pkg::TAG_E_BIT], lk_tag[utt_pkg::TAG_U_BIT]};

  // Relocate bit chosen per access kind
  wire reloc   = req_instr ? ir_reg : dr_reg;
  wire xl_hit  = reloc & lk_any;

  // Registered lookup response; faulting requests return the raw address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_reg <= 1'b0;
      rsp_addr_reg  <= utt_pkg::RST_WORD;
      rsp_miss_reg  <= 1'b0;
      rsp_prot_reg  <= 1'b0;
      rsp_attr_reg  <= 6'h00;
    end else if (ce) begin
      rsp_valid_reg <= req_valid;
      if (req_valid) begin
        rsp_addr_reg <= (xl_hit & perm_ok) ? ra_xl : req_ea;
        rsp_attr_reg <= xl_hit ? lk_attr : 6'h00;
      end
      rsp_miss_reg <= req_valid & reloc & ~lk_any;
      rsp_prot_reg <= req_valid & xl_hit & ~perm_ok;
    end
  end

  // Relocate bits; an interrupt wins over a same-cycle software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_reg <= utt_pkg::RST_RELOC;
      dr_reg <= utt_pkg::RST_RELOC;
    end else if (ce) begin
      if (irq_entry) begin
        ir_reg <= 1'b0;
        dr_reg <= 1'b0;
      end else if (wr_ctrl) begin
        ir_reg <= pwdata[utt_pkg::CTRL_IR_BIT];
        dr_reg <= pwdata[utt_pkg::CTRL_DR_BIT];
      end
    end
  end

  // Process id: software write, or loaded back by an entry read
  wire [PW-1:0] rd_tid = tid_mem[idx_reg];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pid_reg <= utt_pkg::RST_PID;
    end else if (ce) begin
      if (cmd_rd_tag) pid_reg <= rd_tid;
      else if (wr_pid) pid_reg <= pwdata[PW-1:0];
    end
  end

  // Staging words, zone word, index and search result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zone_protection_reg <= utt_pkg::RST_WORD;
      idx_reg             <= '0;
      tag_stage_reg       <= utt_pkg::RST_TAG;
      dat_stage_reg       <= utt_pkg::RST_WORD;
      search_ea_reg       <= utt_pkg::RST_WORD;
      srch_hit_reg        <= 1'b0;
      srch_idx_reg        <= '0;
    end else if (ce) begin
      if (wr_zone)   zone_protection_reg <= pwdata;
      if (wr_index)  idx_reg <= pwdata[IW-1:0];
      if (wr_search) search_ea_reg <= pwdata;
      if (cmd_rd_tag) tag_stage_reg <= tag_mem[idx_reg];
      else if (wr_tag) tag_stage_reg <= pwdata[TW-1:0];
      if (cmd_rd_dat) dat_stage_reg <= dat_mem[idx_reg];
      else if (wr_data) dat_stage_reg <= pwdata;
      if (cmd_search) begin
        srch_hit_reg <= |sr_hit;
        srch_idx_reg <= sr_idx;
      end
    end
  end

  // Read mux; unmapped addresses read zero and flag an error
  wire [31:0] rd_mux =
    (paddr == utt_pkg::OFF_CTRL)   ? {30'h0, dr_reg, ir_reg} :
    (paddr == utt_pkg::OFF_PID)    ? {24'h0, pid_reg} :
    (paddr == utt_pkg::OFF_ZONE)   ? zone_protection_reg :
    (paddr == utt_pkg::OFF_INDEX)  ? {{(32-IW){1'b0}}, idx_reg} :
    (paddr == utt_pkg::OFF_TAG)    ? {4'h0, tag_stage_reg} :
    (paddr == utt_pkg::OFF_DATA)   ? dat_stage_reg :
    (paddr == utt_pkg::OFF_SEARCH) ? search_ea_reg :
    (paddr == utt_pkg::OFF_STATUS) ? {srch_hit_reg, {(31-IW){1'b0}}, srch_idx_reg} :
    32'h00000000;

  // One wait state on every access keeps prdata from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= utt_pkg::RST_WORD;
    end else if (ce) begin
      // Refused accesses still finish with the same single wait state
      pready_reg  <= apb_acc & ~pready_reg;
      pslverr_reg <= apb_acc & ~pready_reg & ~addr_ok;
      if (apb_acc & ~pready_reg & ~pwrite) prdata_reg <= rd_mux;
    end
  end

  // Outputs straight from flops
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign rsp_valid      = rsp_valid_reg;
  assign rsp_real_addr  = rsp_addr_reg;
  assign rsp_miss       = rsp_miss_reg;
  assign rsp_prot_fault = rsp_prot_reg;
  assign rsp_attr       = rsp_attr_reg;

  // Checks; all but freeze_a look only at cycles with the enable high
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pass_through_a: assert property (ce && req_valid && !reloc |=>
    rsp_real_addr == $past(req_ea) && !rsp_miss && !rsp_prot_fault)
    else $error("untranslated address changed");
  irq_clear_a: assert property (ce && irq_entry |=> !ir_reg && !dr_reg)
    else $error("relocate bits not cleared on interrupt");
  resp_latency_a: assert property (ce && req_valid |=> rsp_valid)
    else $error("response not one cycle after request");
  miss_flag_a: assert property (ce && req_valid && reloc && !lk_any |=>
    rsp_miss && rsp_real_addr == $past(req_ea))
    else $error("miss not flagged");
  page_offset_a: assert property (ce && req_valid && xl_hit && perm_ok |=>
    rsp_real_addr[9:0] == $past(req_ea[9:0]) && !rsp_miss)
    else $error("page offset not passed through");
  inval_all_a: assert property (ce && cmd_inval && !cmd_wr_tag |=> vld_vec == '0)
    else $error("entries still valid after invalidate");
  tid_load_a: assert property (ce && cmd_wr_tag |=>
    tid_mem[$past(idx_reg)] == $past(pid_reg))
    else $error("identifier not taken from pid");
  tid_read_a: assert property (ce && cmd_rd_tag |=> pid_reg == $past(rd_tid))
    else $error("identifier not returned to pid");
  store_prot_a: assert property (ce && req_valid && xl_hit && req_store &&
    !req_instr && !wr_ok |=> rsp_prot_fault)
    else $error("store to protected page not faulted");
  zone_none_a: assert property (ce && req_valid && xl_hit && zone ==
    utt_pkg::ZONE_NONE |=> rsp_prot_fault)
    else $error("zone denial not faulted");
  apb_wait_a: assert property (ce && apb_acc && !pready_reg |=> pready_reg ##1 !pready_reg)
    else $error("apb ready not a single pulse");

  // Refused addresses answer on time, flagged
  bad_addr_a: assert property (ce && apb_acc && !pready_reg && !addr_ok |=>
    pready && pslverr)
    else $error("bad address not refused");

  // A fault hands back the raw address so software can retry the access
  fault_raw_a: assert property (ce && req_valid && xl_hit && !perm_ok |=>
    rsp_real_addr == $past(req_ea) && !rsp_miss)
    else $error("faulting access not returned raw");

  // Guarded pages hold device registers, never code
  guard_fetch_a: assert property (ce && req_valid && req_instr && xl_hit &&
    guarded |=> rsp_prot_fault)
    else $error("fetch from guarded page not faulted");

  // Attributes only leave with an access that hits under relocation, faulting or not
  attr_clear_a: assert property (ce && req_valid && !xl_hit |=>
    rsp_attr == 6'h00)
    else $error("attributes shown without translation");

  // No request, no response; a stale flag would fault a later access
  idle_resp_a: assert property (ce && !req_valid |=>
    !rsp_valid && !rsp_miss && !rsp_prot_fault)
    else $error("response without request");

  // Enable low must hold state, bus handshake included
  freeze_a: assert property (!ce |=> $stable(rsp_valid) && $stable(pready) &&
    $stable(ir_reg) && $stable(dr_reg) && $stable(pid_reg))
    else $error("state moved while clock enable low");

  // Main scenarios reached
  hit_c: cover property (ce && req_valid && xl_hit && perm_ok ##1 rsp_valid);
  miss_c: cover property (ce && req_valid && reloc && !lk_any);
  prot_c: cover property (ce && req_valid && xl_hit && !perm_ok);
  search_c: cover property (ce && cmd_search && (|sr_hit));
  freeze_c: cover property (!ce ##1 ce);
endmodule : utt_unified_tlb
